// file: rtl/dispatch_control.sv
`timescale 1ns/1ps
`include "pipe_ctl_consts.svh"
// Functional notes
// - Fetch works on fixed groups of eight instruction words moving as one unit.
// - A fetch group holds one to eight issue groups of parallel instructions.
// - Unstalled, a new fetch group starts address generation every cycle.
// - Dispatch reads chaining bits and stalls when more than one issue group exists.
// - While stalled, remaining issue groups dispatch one per cycle in program order.
// - Stall releases when the last issue group moves toward decode.
// - During the stall younger fetch groups hold and no new address starts.
// - After release, one fetch group advances per cycle again.
// - Idle instruction carries an optional cycle count for a multicycle idle.
// - Multicycle idle adds delay cycles after its group; it and earlier groups are not delayed.
// - Idle of two beside a multiply makes the product visible to next group.
// - A single-cycle idle alongside others changes nothing.
// - During a long idle only its own issue group operates.
// - Idle of five issued in cycle 6 lets the next group execute in cycle 11.
// - A branch finishing its delay slots ends a multicycle idle early.
// - Branch in cycle 1 has slots 2 to 6; target executes in cycle 7.
// - Multiply has exactly one delay slot.
// - Branch in first execute phase sees its target in address generation.
module dispatch_control
    import pipe_ctl_pkg::*;
#(
    parameter int SLOTS = `SLOTS_PER_FETCH_GROUP,
    parameter int IW    = `INSTR_WIDTH,
    parameter int CW    = `IDLE_COUNT_WIDTH
)
(
    input  wire logic                clk_i,
    input  wire logic                reset_i,
    input  wire logic                fetch_valid_i,
    input  wire logic [SLOTS*IW-1:0] fetch_words_i,
    input  wire logic                branch_taken_i,
    output logic                     fetch_addr_generate_phase_o,
    output logic                     fetch_advance_o,
    output logic                     dispatch_stall_o,
    output logic [SLOTS-1:0]         decode_slot_valid_o,
    output logic [SLOTS*IW-1:0]      decode_words_o,
    output logic                     first_execute_valid_o,
    output logic [SLOTS-1:0]         first_execute_slot_o,
    output logic                     result_visible_o,
    output logic                     idle_active_o
);
    localparam int STAGES = `FETCH_PHASE_COUNT;
    localparam logic [2:0] BR_SLOTS = 3'(`BRANCH_DELAY_SLOTS);

    if (SLOTS < 2 || SLOTS > 8 || CW < 3 || IW < 8)
    begin : g_bad_params
        $error("dispatch_control: unsupported parameters");
    end

    // Fetch phases: generate, send, wait, receive, then dispatch register
    logic [STAGES-1:0]         stage_valid;
    logic [IW*SLOTS-1:0]       stage_words [STAGES];
    logic [STAGES-1:0]         next_stage_valid;
    logic [IW*SLOTS-1:0]       next_stage_words [STAGES];
    logic                      disp_valid;
    logic [IW*SLOTS-1:0]       disp_words;
    logic [SLOTS-1:0]          disp_done;
    logic                      next_disp_valid;
    logic [IW*SLOTS-1:0]       next_disp_words;
    logic [SLOTS-1:0]          next_disp_done;
    logic [SLOTS-1:0]          chain;
    logic [SLOTS-1:0]          issue_mask;
    logic                      last_group;
    logic                      multi_group;
    logic                      hold;
    logic                      disp_take;

    genvar s;
    generate
        for (s = 0; s < SLOTS; s++)
        begin : g_chain
            assign chain[s] = disp_words[s*IW + `CHAIN_BIT_POS];
        end
    endgenerate

    group_splitter #(.SLOTS(SLOTS)) u_split
    (
        .chain_i       (chain),
        .done_i        (disp_done),
        .issue_mask_o  (issue_mask),
        .last_group_o  (last_group),
        .multi_group_o (multi_group)
    );

    // Issue state and idle counting
    issue_state_t    state;
    issue_state_t    next_state;
    logic [CW-1:0]   idle_left;
    logic [CW-1:0]   next_idle_left;
    logic [2:0]      br_count;
    logic [2:0]      next_br_count;
    logic            br_due;
    logic            mul_pending;
    logic            next_mul_pending;
    logic            mul_e2;
    logic            next_mul_e2;
    logic            product_ready;
    logic            next_product_ready;
    logic            idle_found;
    logic [CW-1:0]   idle_count;
    logic            mul_found;
    logic            exec_valid;
    logic [SLOTS-1:0] exec_slot;
    logic            next_exec_valid;
    logic [SLOTS-1:0] next_exec_slot;
    logic [SLOTS-1:0] dec_valid;
    logic [IW*SLOTS-1:0] dec_words;
    logic [SLOTS-1:0] next_dec_valid;
    logic [IW*SLOTS-1:0] next_dec_words;

    assign idle_active_o = (state == ISSUE_IDLE);
    // Pipeline freezes while an idle period counts; a finishing branch lifts it
    assign hold = idle_active_o && !br_due;
    // Branch finishing its delay slots this cycle
    assign br_due = (br_count == 3'd1);

    always_comb
    begin
        idle_found = 1'b0;
        idle_count = '0;
        mul_found  = 1'b0;
        for (int i = 0; i < SLOTS; i++)
        begin
            if (dec_valid[i]
                && dec_words[i*IW+`IDLE_OPCODE_LSB +: 4] == `IDLE_OPCODE)
            begin
                idle_found = 1'b1;
                idle_count = dec_words[i*IW+`IDLE_COUNT_LSB +: CW];
            end
            if (dec_valid[i]
                && dec_words[i*IW+`IDLE_OPCODE_LSB +: 4] == `MULTIPLY_OPCODE)
                mul_found = 1'b1;
        end
    end

    // Dispatch may take a new fetch group only when current one is done
    assign disp_take = !hold && (!disp_valid || last_group);
    assign dispatch_stall_o = disp_valid && multi_group && !last_group;
    assign fetch_advance_o = disp_take;
    assign fetch_addr_generate_phase_o = disp_take && fetch_valid_i;

    always_comb
    begin
        next_stage_valid = stage_valid;
        for (int i = 0; i < STAGES; i++)
            next_stage_words[i] = stage_words[i];
        next_disp_valid = disp_valid;
        next_disp_words = disp_words;
        next_disp_done  = disp_done;
        // Delay-slot groups keep flowing after a branch; the source offers the target
        if (!hold)
        begin
            if (disp_take)
            begin
                // Whole fetch groups shift one phase per cycle
                next_stage_valid[0] = fetch_valid_i;
                next_stage_words[0] = fetch_words_i;
                for (int i = 1; i < STAGES; i++)
                begin
                    next_stage_valid[i] = stage_valid[i-1];
                    next_stage_words[i] = stage_words[i-1];
                end
                next_disp_valid = stage_valid[STAGES-1];
                next_disp_words = stage_words[STAGES-1];
                next_disp_done  = '0;
            end
            else
            begin
                next_disp_done = disp_done | issue_mask;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            stage_valid <= '0;
            disp_valid  <= 1'b0;
            disp_done   <= '0;
        end
        else
        begin
            stage_valid <= next_stage_valid;
            disp_valid  <= next_disp_valid;
            disp_done   <= next_disp_done;
        end
        for (int i = 0; i < STAGES; i++)
            stage_words[i] <= next_stage_words[i];
        disp_words <= next_disp_words;
    end

    // Decode register gets one issue group per cycle
    always_comb
    begin
        next_dec_valid = dec_valid;
        next_dec_words = dec_words;
        if (!hold)
        begin
            next_dec_valid = disp_valid ? issue_mask : '0;
            next_dec_words = disp_words;
        end
    end

    always_comb
    begin
        next_state       = state;
        next_idle_left   = idle_left;
        next_exec_valid  = 1'b0;
        next_exec_slot   = '0;
        next_mul_pending = mul_found && !hold;
        next_mul_e2      = mul_pending;
        next_product_ready = mul_e2 || (product_ready && !mul_pending);
        next_br_count    = (br_count != 3'd0) ? br_count - 3'd1 : 3'd0;
        if (branch_taken_i)
            next_br_count = BR_SLOTS;
        case (state)
            ISSUE_RUN:
            begin
                next_exec_valid = |dec_valid;
                next_exec_slot  = dec_valid;
                // Count of one or zero behaves as a plain idle
                if (idle_found && idle_count > CW'(1))
                begin
                    next_state     = ISSUE_IDLE;
                    next_idle_left = idle_count - CW'(1);
                end
            end
            ISSUE_IDLE:
            begin
                if (br_due)
                begin
                    // Branch target issues right after the last delay slot
                    next_state      = ISSUE_RUN;
                    next_idle_left  = '0;
                    next_exec_valid = |dec_valid;
                    next_exec_slot  = dec_valid;
                end
                else if (idle_left == CW'(1))
                begin
                    next_state     = ISSUE_RUN;
                    next_idle_left = '0;
                end
                else
                begin
                    next_idle_left = idle_left - CW'(1);
                end
            end
            default:
            begin
                next_state     = ISSUE_RUN;
                next_idle_left = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            state       <= ISSUE_RUN;
            idle_left   <= '0;
            br_count    <= 3'd0;
            mul_pending <= 1'b0;
            mul_e2      <= 1'b0;
            product_ready <= 1'b0;
            exec_valid  <= 1'b0;
            exec_slot   <= '0;
            dec_valid   <= '0;
            dec_words   <= '0;
        end
        else
        begin
            state       <= next_state;
            idle_left   <= next_idle_left;
            br_count    <= next_br_count;
            mul_pending <= next_mul_pending;
            mul_e2      <= next_mul_e2;
            product_ready <= next_product_ready;
            exec_valid  <= next_exec_valid;
            exec_slot   <= next_exec_slot;
            dec_valid   <= next_dec_valid;
            dec_words   <= next_dec_words;
        end
    end

    // Product is written at the end of the second execute phase, readable after it
    assign result_visible_o = product_ready;
    assign decode_slot_valid_o   = dec_valid;
    assign decode_words_o        = dec_words;
    assign first_execute_valid_o = exec_valid;
    assign first_execute_slot_o  = exec_slot;

    a_stall_holds_fetch: assert property (@(posedge clk_i) disable iff (reset_i)
        dispatch_stall_o |-> !fetch_addr_generate_phase_o)
        else $error("address generated during dispatch stall");

    a_stall_walks_groups: assert property (@(posedge clk_i) disable iff (reset_i)
        (dispatch_stall_o && !hold && !branch_taken_i) |=> (disp_done != $past(disp_done)))
        else $error("stalled dispatch made no progress");

    a_idle_blocks_exec: assert property (@(posedge clk_i) disable iff (reset_i)
        (idle_active_o && !br_due) |=> !first_execute_valid_o)
        else $error("execution during idle period");

    a_branch_target_exec: assert property (@(posedge clk_i) disable iff (reset_i)
        (idle_active_o && br_due && (|dec_valid)) |=> first_execute_valid_o)
        else $error("branch target not issued after delay slots");

    a_idle_five_len: assert property (@(posedge clk_i) disable iff (reset_i)
        ($rose(idle_active_o) && $past(idle_count) == CW'(5) && br_count == 3'd0)
        |-> idle_active_o [*4] ##1 !idle_active_o)
        else $error("idle of five wrong length");

    a_branch_ends_idle: assert property (@(posedge clk_i) disable iff (reset_i)
        (idle_active_o && br_due) |=> !idle_active_o)
        else $error("branch did not end idle");

    a_branch_slots: assert property (@(posedge clk_i) disable iff (reset_i)
        branch_taken_i |=> br_count == BR_SLOTS)
        else $error("branch slot count wrong");

    a_single_idle: assert property (@(posedge clk_i) disable iff (reset_i)
        (state == ISSUE_RUN && idle_found && idle_count <= CW'(1)) |=> !idle_active_o)
        else $error("single idle stalled issue");

    a_release_take: assert property (@(posedge clk_i) disable iff (reset_i)
        (disp_valid && last_group && !hold) |-> fetch_advance_o)
        else $error("stall not released on last group");

    a_mul_visible: assert property (@(posedge clk_i) disable iff (reset_i)
        (mul_found && !hold && state == ISSUE_RUN) |-> ##3 result_visible_o)
        else $error("multiply result not visible");
endmodule : dispatch_control

// file: rtl/pipe_ctl_consts.svh
`ifndef PIPE_CTL_CONSTS_SVH
`define PIPE_CTL_CONSTS_SVH

`define SLOTS_PER_FETCH_GROUP   8
`define FETCH_PHASE_COUNT       4
`define MULTIPLY_DELAY_SLOTS    1
`define BRANCH_DELAY_SLOTS      5
`define IDLE_COUNT_WIDTH        4
`define INSTR_WIDTH             32
`define CHAIN_BIT_POS           0
`define IDLE_OPCODE_MSB         31
`define IDLE_OPCODE_LSB         28
`define IDLE_OPCODE             4'h0
`define IDLE_COUNT_MSB          4
`define IDLE_COUNT_LSB          1
`define BRANCH_OPCODE           4'h1
`define MULTIPLY_OPCODE         4'h2

`endif

// file: rtl/pipe_ctl_pkg.sv
package pipe_ctl_pkg;
    typedef enum logic [2:0]
    {
        ISSUE_RUN  = 3'b001,
        ISSUE_IDLE = 3'b010,
        ISSUE_HALT = 3'b100
    } issue_state_t;
endpackage : pipe_ctl_pkg

// file: rtl/group_splitter.sv
`timescale 1ns/1ps
`include "pipe_ctl_consts.svh"

// Finds issue group boundaries from the chaining bits of one fetch group
module group_splitter
#(
    parameter int SLOTS = `SLOTS_PER_FETCH_GROUP
)
(
    input  wire logic [SLOTS-1:0] chain_i,
    input  wire logic [SLOTS-1:0] done_i,
    output logic      [SLOTS-1:0] issue_mask_o,
    output logic                  last_group_o,
    output logic                  multi_group_o
);
    logic [SLOTS-1:0] open_mask;
    logic [SLOTS:0]   run;
    logic [SLOTS-1:0] ends;

    assign open_mask = ~done_i;
    assign run[0] = 1'b1;

    // Mask covers the first not-yet-issued slot up to the first unchained slot
    genvar g;
    generate
        for (g = 0; g < SLOTS; g++)
        begin : g_slot
            assign issue_mask_o[g] = open_mask[g] & run[g];
            assign run[g+1] = run[g] & (done_i[g] | chain_i[g]);
            assign ends[g] = ~chain_i[g];
        end
    endgenerate

    assign last_group_o  = ~|(open_mask & ~issue_mask_o);
    assign multi_group_o = |ends[SLOTS-2:0];
endmodule : group_splitter

// file: verification/fetch_mem_model.sv
`timescale 1ns/1ps
`include "pipe_ctl_consts.svh"

// Program memory: offers fetch groups in order, steps on each acceptance
module fetch_mem_model
(
    input  wire logic                                            clk_i,
    input  wire logic                                            reset_i,
    input  wire logic                                            accept_i,
    output logic                                                 valid_o,
    output logic [`SLOTS_PER_FETCH_GROUP*`INSTR_WIDTH-1:0]       words_o
);
    logic [`SLOTS_PER_FETCH_GROUP*`INSTR_WIDTH-1:0] prog [0:15];
    int                                             count;
    int                                             ptr;

    initial
    begin
        count = 0;
        ptr = 0;
        valid_o = 1'b0;
        words_o = '0;
    end

    always @(posedge clk_i)
    begin
        if (reset_i)
            ptr = 0;
        else if (accept_i && valid_o)
            ptr = ptr + 1;
        #1;
        valid_o = (ptr < count);
        // Nothing offered: flip the stale words so they never pass for data
        words_o = valid_o ? prog[ptr] : ~words_o;
    end
endmodule : fetch_mem_model

// file: verification/dispatch_stall_and_multicycle_idle_test.sv
`timescale 1ns/1ps
`include "pipe_ctl_consts.svh"
`define CHECK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin errors++; \
    $display("BAD %s expected %0h seen %0h", nm, ex, got); end end

module dispatch_stall_and_multicycle_idle_test;
    localparam int FW = `SLOTS_PER_FETCH_GROUP * `INSTR_WIDTH;
    logic          clk_i;
    logic          reset_i;
    logic          fetch_valid_i;
    logic [FW-1:0] fetch_words_i;
    logic          branch_taken_i;
    logic          accept;
    logic          advance;
    logic          stall;
    logic [7:0]    dec_valid;
    logic [FW-1:0] dec_words;
    logic          exe_valid;
    logic [7:0]    exe_slot;
    logic          visible;
    logic          idle;
    int            errors;
    int            num_checks;
    int            acc_n;
    int            stall_n;
    int            bad_adv;
    int            idle_n;
    int            br;
    int            exe_cyc[$];
    logic [7:0]    dec_q[$];
    logic [7:0]    exe_q[$];
    logic [FW-1:0] word_q[$];
    logic          vis_q[$];

    dispatch_control dispatch_control_i (.clk_i(clk_i), .reset_i(reset_i),
        .fetch_valid_i(fetch_valid_i), .fetch_words_i(fetch_words_i),
        .branch_taken_i(branch_taken_i), .fetch_addr_generate_phase_o(accept),
        .fetch_advance_o(advance), .dispatch_stall_o(stall), .decode_slot_valid_o(dec_valid),
        .decode_words_o(dec_words), .first_execute_valid_o(exe_valid),
        .first_execute_slot_o(exe_slot), .result_visible_o(visible), .idle_active_o(idle));

    fetch_mem_model fetch_mem_model_i (.clk_i(clk_i), .reset_i(reset_i), .accept_i(accept),
        .valid_o(fetch_valid_i), .words_o(fetch_words_i));

    always #50 clk_i = ~clk_i;

    function automatic logic [FW-1:0] fg(input logic [7:0] chain, input logic [3:0] op0 = 4'h3,
                                         input logic [3:0] cnt = 4'h0,
                                         input logic [3:0] op1 = 4'h3);
        logic [FW-1:0] w;
        for (int s = 0; s < 8; s++)
            w[s*32+:32] = {4'h3, 23'h000000, 4'h0, chain[s]};
        w[31:0] = {op0, 23'h000000, cnt, chain[0]};
        w[63:32] = {op1, 23'h000000, 4'h0, chain[1]};
        return w;
    endfunction : fg

    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // Loads nothing; resets, runs n cycles and records what the block issued
    task automatic run(input int n, input bit do_branch);
        reset_i = 1'b1;
        acc_n = 0;
        stall_n = 0;
        bad_adv = 0;
        idle_n = 0;
        br = -1;
        exe_cyc.delete();
        dec_q.delete();
        exe_q.delete();
        word_q.delete();
        vis_q.delete();
        repeat (3) @(posedge clk_i);
        #1;
        reset_i = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            branch_taken_i = (i == br);
            @(negedge clk_i);
            if (accept === 1'b1) acc_n++;
            if (stall === 1'b1)
            begin
                stall_n++;
                if (accept !== 1'b0 || advance !== 1'b0) bad_adv++;
            end
            if (dec_valid !== 8'h00)
            begin
                dec_q.push_back(dec_valid);
                word_q.push_back(dec_words);
            end
            if (exe_valid === 1'b1)
            begin
                exe_cyc.push_back(i);
                exe_q.push_back(exe_slot);
                vis_q.push_back(visible);
                if (do_branch && br < 0) br = i + 1;
            end
            if (idle === 1'b1) idle_n++;
            @(posedge clk_i);
            #1;
        end
        branch_taken_i = 1'b0;
    endtask : run

    task automatic check_groups(input logic [7:0] m[$]);
        `CHECK("groups", m.size(), exe_q.size())
        foreach (m[k])
        begin
            `CHECK("decode_mask", m[k], dec_q[k])
            `CHECK("exec_mask", m[k], exe_q[k])
            `CHECK("exec_cycle", exe_cyc[0] + k, exe_cyc[k])
        end
    endtask : check_groups

    task automatic load_singles(input int first, input int last);
        for (int k = first; k <= last; k++)
            fetch_mem_model_i.prog[k] = fg(8'h7f);
        fetch_mem_model_i.count = last + 1;
    endtask : load_singles

    task automatic sc_stream;
        load_singles(0, 5);
        run(20, 1'b0);
        `CHECK("stall_cycles", 0, stall_n)
        `CHECK("accepts", 6, acc_n)
        `CHECK("first_exec", 7, exe_cyc[0])
        `CHECK("words", fetch_mem_model_i.prog[5], word_q[5])
        check_groups('{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff});
    endtask : sc_stream

    task automatic sc_stall;
        load_singles(1, 7);
        fetch_mem_model_i.prog[0] = fg(8'h76);
        run(30, 1'b0);
        `CHECK("stall_seen", 1'b1, stall_n > 0)
        `CHECK("fetch_held", 0, bad_adv)
        `CHECK("accepts", 8, acc_n)
        `CHECK("held_words", fetch_mem_model_i.prog[0], word_q[2])
        check_groups('{8'h01, 8'h0e, 8'hf0, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff});
    endtask : sc_stall

    task automatic sc_eight;
        load_singles(1, 1);
        fetch_mem_model_i.prog[0] = fg(8'h00);
        run(24, 1'b0);
        `CHECK("fetch_held", 0, bad_adv)
        check_groups('{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'hff});
    endtask : sc_eight

    // Second fetch group holds an idle of the given count beside a multiply
    task automatic idle_case(input logic [3:0] cnt);
        load_singles(0, 3);
        fetch_mem_model_i.prog[1] = fg(8'h7f, `IDLE_OPCODE, cnt, `MULTIPLY_OPCODE);
        run(30, 1'b0);
        `CHECK("earlier_gap", 1, exe_cyc[1] - exe_cyc[0])
        `CHECK("own_visible", 1'b0, vis_q[1])
    endtask : idle_case

    task automatic sc_idle_one;
        idle_case(4'h1);
        `CHECK("idle_gap", 1, exe_cyc[2] - exe_cyc[1])
        `CHECK("idle_cycles", 0, idle_n)
        `CHECK("next_visible", 1'b0, vis_q[2])
        `CHECK("later_visible", 1'b1, vis_q[3])
    endtask : sc_idle_one

    task automatic sc_idle_two;
        idle_case(4'h2);
        `CHECK("idle_gap", 2, exe_cyc[2] - exe_cyc[1])
        `CHECK("idle_seen", 1'b1, idle_n > 0)
        `CHECK("next_visible", 1'b1, vis_q[2])
    endtask : sc_idle_two

    task automatic sc_idle_five;
        idle_case(4'h5);
        `CHECK("idle_gap", 5, exe_cyc[2] - exe_cyc[1])
        `CHECK("groups", 4, exe_q.size())
    endtask : sc_idle_five

    task automatic sc_branch;
        int n;
        load_singles(0, 9);
        fetch_mem_model_i.prog[6] = fg(8'h7f, `IDLE_OPCODE, 4'h5);
        run(30, 1'b1);
        n = 0;
        foreach (exe_cyc[k])
            if (exe_cyc[k] > br && exe_cyc[k] <= br + 6) n++;
        `CHECK("slots_and_target", 6, n)
    endtask : sc_branch

    initial
    begin
        clk_i = 1'b0;
        reset_i = 1'b1;
        branch_taken_i = 1'b0;
        errors = 0;
        num_checks = 0;
        repeat (12) @(posedge clk_i);
        #1;
        sc_stream;
        sc_stall;
        sc_eight;
        sc_idle_one;
        sc_idle_two;
        sc_idle_five;
        sc_branch;
        end_of_test;
    end

    initial
    begin
        repeat (2000) @(posedge clk_i);
        errors++;
        $display("BAD watchdog expected done seen timeout");
        end_of_test;
    end
endmodule : dispatch_stall_and_multicycle_idle_test
